/* include/clk_mode_pkg.sv */
// Package with constants and carrier types for the clock mode control block
package clk_mode_pkg;

  // ----------------------------------------------------------------
  // Division and ratio constants
  // ----------------------------------------------------------------
  localparam int unsigned RESET_DIV = 8;        // Main clock divided by eight after reset
  localparam int unsigned DIV_MID = 4;          // Divide ratio with division bit clear and choice 1 or 3
  localparam int unsigned DIV_HIGH = 2;         // Divide ratio in high-speed choice
  localparam int unsigned MIN_RATIO = 3;        // Main must exceed this many times sub
  localparam int unsigned DIV_W = 3;            // Width of the divider counter

  // ----------------------------------------------------------------
  // Mode bit reset values
  // ----------------------------------------------------------------
  localparam logic SRC_SEL_RST = 1'b0;          // Main oscillator selected at reset
  localparam logic DIV_CTL_RST = 1'b1;          // Divide-by-eight selected at reset
  localparam logic [1:0] DIV_SEL_RST = 2'h0;    // Divide choice field reset value

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  localparam int unsigned SEG_PINS = 24;        // Segment-shared port pins
  localparam int unsigned PORT_PINS = 19;       // Other port pins
  localparam int unsigned COM_PINS = 4;         // Common outputs

  // Power state, Gray coded along run -> wait -> stop
  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP = 2'b11
  } pwr_state_e;

  // Mode control word from the core
  typedef struct packed {
    logic src_sel;                              // System clock source select bit
    logic div_ctl;                              // Clock division control bit
    logic [1:0] div_sel;                        // 0: /8, 1: /4, 2: /2
  } mode_ctl_s;

  // Clock output control
  typedef struct packed {
    logic en_a;                                 // Drive clock on pin a
    logic en_b;                                 // Drive clock on pin b
    logic sel_sub;                              // 1: sub oscillator, 0: main
  } clk_out_ctl_s;

endpackage

/* rtl/clock_mode_control.sv */
// Reset pin states and system clock mode control
module clock_mode_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic main_oscillator_input,
  input wire logic sub_oscillator_input,
  input wire clk_mode_pkg::mode_ctl_s mode_ctl,
  input wire logic mode_wr,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic wake_req,
  input wire clk_mode_pkg::clk_out_ctl_s clk_out_ctl,
  output logic sys_clk_en,
  output logic periph_clk_en,
  output logic cpu_run,
  output logic [1:0] pwr_state,
  output logic mode_src_sub,
  output logic [clk_mode_pkg::SEG_PINS-1:0] seg_pullup_en,
  output logic [clk_mode_pkg::SEG_PINS-1:0] seg_force_in,
  output logic [clk_mode_pkg::PORT_PINS-1:0] port_force_hiz,
  output logic [clk_mode_pkg::COM_PINS-1:0] lcd_common_level,
  output logic clock_out_port_pin_a,
  output logic clock_out_port_pin_a_oe,
  output logic clock_out_port_pin_b,
  output logic clock_out_port_pin_b_oe
);
  import clk_mode_pkg::*;

  // ----------------------------------------------------------------
  // Oscillator synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] main_sync_r;                      // Two-stage main sync
  logic [1:0] sub_sync_r;                       // Two-stage sub sync
  logic main_prev_r;                            // Previous synced main level
  logic sub_prev_r;                             // Previous synced sub level
  logic main_tick;                              // Main rising edge
  logic sub_tick;                               // Sub rising edge

  // Sample oscillators through two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      main_sync_r <= 2'h0;
      sub_sync_r <= 2'h0;
      main_prev_r <= 1'b0;
      sub_prev_r <= 1'b0;
    end else begin
      main_sync_r <= {main_sync_r[0], main_oscillator_input};
      sub_sync_r <= {sub_sync_r[0], sub_oscillator_input};
      main_prev_r <= main_sync_r[1];
      sub_prev_r <= sub_sync_r[1];
    end
  end

  assign main_tick = main_sync_r[1] & ~main_prev_r;
  assign sub_tick = sub_sync_r[1] & ~sub_prev_r;

  // ----------------------------------------------------------------
  // Mode bits
  // ----------------------------------------------------------------
  mode_ctl_s mode_r;                            // Active clock mode
  pwr_state_e pwr_r;                            // Power state

  // Latch mode writes; held through stop and wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r.src_sel <= SRC_SEL_RST;
      mode_r.div_ctl <= DIV_CTL_RST;
      mode_r.div_sel <= DIV_SEL_RST;
    end else if (mode_wr && pwr_r == PWR_RUN) begin
      // Ordering and stability left to software
      mode_r <= mode_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  // Enter stop or wait from any clock mode; mode_r kept as is
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_r <= PWR_RUN;
    end else begin
      case (pwr_r)
        PWR_RUN: begin
          if (stop_req) begin
            pwr_r <= PWR_STOP;
          end else if (wait_req) begin
            pwr_r <= PWR_WAIT;
          end
        end
        PWR_WAIT: begin
          if (wake_req) begin
            pwr_r <= PWR_RUN;
          end
        end
        PWR_STOP: begin
          if (wake_req) begin
            pwr_r <= PWR_RUN;
          end
        end
        default: begin
          pwr_r <= PWR_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Divider on main oscillator ticks
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_r;                  // Main tick counter
  logic [DIV_W-1:0] div_last;                   // Terminal count for ratio
  logic main_div_tick;                          // Divided main tick

  // Ratio: /8 when division bit set or choice 0, else /4 or /2
  always_comb begin
    if (mode_r.div_ctl || mode_r.div_sel == 2'h0) begin
      div_last = DIV_W'(RESET_DIV - 1);
    end else if (mode_r.div_sel == 2'h2) begin
      div_last = DIV_W'(DIV_HIGH - 1);
    end else begin
      div_last = DIV_W'(DIV_MID - 1);
    end
  end

  // Count main edges; wrap at the terminal count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_r <= '0;
    end else if (main_tick) begin
      div_cnt_r <= (div_cnt_r >= div_last) ? '0 : div_cnt_r + 1'b1;
    end
  end

  assign main_div_tick = main_tick && (div_cnt_r >= div_last);

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  logic src_tick;                               // Tick of selected source

  // Source bit chooses sub or divided main
  assign src_tick = mode_r.src_sel ? sub_tick : main_div_tick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      // Core clock gated in wait and stop
      sys_clk_en <= src_tick && (pwr_r == PWR_RUN);
      // Timers and LCD run in wait, halt in stop
      periph_clk_en <= src_tick && (pwr_r != PWR_STOP);
    end
  end

  assign cpu_run = (pwr_r == PWR_RUN);
  assign pwr_state = pwr_r;
  assign mode_src_sub = mode_r.src_sel;

  // ----------------------------------------------------------------
  // Reset pin states
  // ----------------------------------------------------------------
  // Segment ports pulled-up inputs, others hi-Z, commons high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seg_pullup_en <= '1;
      seg_force_in <= '1;
      port_force_hiz <= '1;
      lcd_common_level <= '1;
    end else begin
      seg_pullup_en <= '0;
      seg_force_in <= '0;
      port_force_hiz <= '0;
      lcd_common_level <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Oscillation external output
  // ----------------------------------------------------------------
  logic out_clk;                                // Selected clock level

  assign out_clk = clk_out_ctl.sel_sub ? sub_sync_r[1] : main_sync_r[1];

  // Drive chosen oscillator onto the two port pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_out_port_pin_a <= 1'b0;
      clock_out_port_pin_b <= 1'b0;
      clock_out_port_pin_a_oe <= 1'b0;
      clock_out_port_pin_b_oe <= 1'b0;
    end else begin
      clock_out_port_pin_a <= clk_out_ctl.en_a & out_clk;
      clock_out_port_pin_b <= clk_out_ctl.en_b & out_clk;
      clock_out_port_pin_a_oe <= clk_out_ctl.en_a;
      clock_out_port_pin_b_oe <= clk_out_ctl.en_b;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Edge after reset seen high: all pin-state controls asserted
  a_reset_pin_state: assert property (@(posedge sys_clk)
    rst |=> (&seg_pullup_en && &seg_force_in && &port_force_hiz && &lcd_common_level))
    else $error("pin states wrong after reset");

  // Reset leaves main source, divide-by-eight and a cleared divider
  a_reset_div_eight: assert property (@(posedge sys_clk)
    rst |=> (mode_r.div_ctl && !mode_r.src_sel && div_last == 3'h7 && div_cnt_r == 3'h0))
    else $error("divide-by-eight not in force after reset");

  a_mode_kept_sleep: assert property (@(posedge sys_clk) disable iff (rst)
    (pwr_r != PWR_RUN) |=> $stable(mode_r))
    else $error("clock mode changed in stop or wait");

  a_wait_periph_runs: assert property (@(posedge sys_clk) disable iff (rst)
    (pwr_r == PWR_WAIT && src_tick) |=> (periph_clk_en && !sys_clk_en))
    else $error("peripherals not clocked in wait");

  a_src_select_sub: assert property (@(posedge sys_clk) disable iff (rst)
    (pwr_r == PWR_RUN && mode_r.src_sel && sub_tick) |=> sys_clk_en)
    else $error("sub oscillator tick not passed");

  a_clk_out_oe: assert property (@(posedge sys_clk) disable iff (rst)
    clk_out_ctl.en_a |=> clock_out_port_pin_a_oe)
    else $error("clock out pin a not driven");

endmodule

/* test/tb_top.sv */
// Self-checking bench for the clock mode control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import clk_mode_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  localparam int MAIN_CYC = 8; // Main oscillator period in sys_clk cycles
  localparam int SUB_CYC = 50; // Sub oscillator period in sys_clk cycles
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic main_oscillator_input = 1'b0;
  logic sub_oscillator_input = 1'b0;
  mode_ctl_s mode_ctl = '0;
  clk_out_ctl_s clk_out_ctl = '0;
  logic mode_wr = 1'b0;
  logic stop_req = 1'b0;
  logic wait_req = 1'b0;
  logic wake_req = 1'b0;
  logic sys_clk_en, periph_clk_en, cpu_run, mode_src_sub;
  logic [1:0] pwr_state;
  logic [SEG_PINS-1:0] seg_pullup_en, seg_force_in;
  logic [PORT_PINS-1:0] port_force_hiz;
  logic [COM_PINS-1:0] lcd_common_level;
  logic pin_a, pin_a_oe, pin_b, pin_b_oe;
  int err_total = 0;
  int compares = 0;
  int ns, np, ra, rb; // Pulse and rising edge counts from watch

  clock_mode_control dut_u (.sys_clk(sys_clk), .rst(rst),
    .main_oscillator_input(main_oscillator_input),
    .sub_oscillator_input(sub_oscillator_input), .mode_ctl(mode_ctl), .mode_wr(mode_wr),
    .stop_req(stop_req), .wait_req(wait_req), .wake_req(wake_req),
    .clk_out_ctl(clk_out_ctl), .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
    .cpu_run(cpu_run), .pwr_state(pwr_state), .mode_src_sub(mode_src_sub),
    .seg_pullup_en(seg_pullup_en), .seg_force_in(seg_force_in),
    .port_force_hiz(port_force_hiz), .lcd_common_level(lcd_common_level),
    .clock_out_port_pin_a(pin_a), .clock_out_port_pin_a_oe(pin_a_oe),
    .clock_out_port_pin_b(pin_b), .clock_out_port_pin_b_oe(pin_b_oe));

  // ------------------------------------------------------------
  // Clocks: offsets keep oscillator edges off sys_clk edges
  // ------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  // Main 32 ns, sub 200 ns: ratio well above three, both stable
  initial begin
    #1;
    forever #16 main_oscillator_input = ~main_oscillator_input;
  end
  initial begin
    #1;
    forever #100 sub_oscillator_input = ~sub_oscillator_input;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One mode write pulse
  task automatic wr_mode(input logic s, input logic d, input logic [1:0] v);
    @(negedge sys_clk);
    mode_ctl = '{s, d, v};
    mode_wr = 1'b1;
    @(negedge sys_clk);
    mode_wr = 1'b0;
  endtask

  // Power request pulse: 0 wait, 1 stop, 2 both, 3 wake
  task automatic req(input int k);
    @(negedge sys_clk);
    wait_req = (k == 0 || k == 2);
    stop_req = (k == 1 || k == 2);
    wake_req = (k == 3);
    @(negedge sys_clk);
    {wait_req, stop_req, wake_req} = 3'h0;
    @(negedge sys_clk);
  endtask

  // Count enable pulses and clock-out rises over a window
  task automatic watch(input int cyc);
    logic pa, pb;
    {ns, np, ra, rb} = '0;
    pa = pin_a;
    pb = pin_b;
    repeat (cyc) begin
      @(negedge sys_clk);
      ns += (sys_clk_en === 1'b1);
      np += (periph_clk_en === 1'b1);
      ra += (pin_a === 1'b1 && pa === 1'b0);
      rb += (pin_b === 1'b1 && pb === 1'b0);
      pa = pin_a;
      pb = pin_b;
    end
  endtask

  // Spacing of the second and third core enable pulses after a change
  task automatic gap(input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (sys_clk_en !== 1'b1 && n < 400);
    end
    chk(n, exp, "core enable spacing");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({&seg_pullup_en, &seg_force_in, &port_force_hiz, &lcd_common_level}, 4'hf, "pins");
    chk({pwr_state, mode_src_sub}, 3'h0, "reset mode");
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({|seg_pullup_en, |seg_force_in, |port_force_hiz, |lcd_common_level}, 4'h0, "pins");
    gap(MAIN_CYC * RESET_DIV);
  endtask

  task automatic test_ratios();
    wr_mode(1'b0, 1'b0, 2'h1);
    gap(MAIN_CYC * DIV_MID);
    wr_mode(1'b0, 1'b0, 2'h0);
    gap(MAIN_CYC * RESET_DIV);
    wr_mode(1'b0, 1'b1, 2'h2);
    gap(MAIN_CYC * RESET_DIV);
    wr_mode(1'b0, 1'b0, 2'h3); // Spare choice falls back to /4
    gap(MAIN_CYC * DIV_MID);
  endtask

  task automatic test_low_speed();
    wr_mode(1'b1, 1'b1, 2'h0); // Source bit first
    repeat (100) @(negedge sys_clk);
    wr_mode(1'b1, 1'b0, 2'h0); // Division bit once stable
    chk(mode_src_sub, 1'b1, "sub source");
    gap(SUB_CYC);
    req(1);
    chk(pwr_state, PWR_STOP, "stop from sub");
    req(3);
    chk({pwr_state, mode_src_sub}, 3'h1, "sub mode kept");
    wr_mode(1'b0, 1'b0, 2'h0);
    repeat (100) @(negedge sys_clk);
    wr_mode(1'b0, 1'b0, 2'h2);
    chk(mode_src_sub, 1'b0, "main source");
    gap(MAIN_CYC * DIV_HIGH);
  endtask

  task automatic test_wait();
    req(0);
    chk({pwr_state, cpu_run}, {PWR_WAIT, 1'b0}, "wait entry");
    wr_mode(1'b1, 1'b1, 2'h0);
    watch(200);
    chk(ns, 0, "core clock in wait");
    chk(np != 0, 1'b1, "timer clock in wait");
    req(3);
    chk({pwr_state, cpu_run, mode_src_sub}, {PWR_RUN, 2'b10}, "wait exit");
    gap(MAIN_CYC * DIV_HIGH);
  endtask

  task automatic test_stop();
    req(2);
    chk({pwr_state, cpu_run}, {PWR_STOP, 1'b0}, "stop entry");
    watch(200);
    chk({ns[7:0], np[7:0]}, 16'h0, "clocks in stop");
    req(3);
    chk(pwr_state, PWR_RUN, "stop exit");
    gap(MAIN_CYC * DIV_HIGH);
  endtask

  task automatic test_clk_out();
    @(negedge sys_clk);
    clk_out_ctl = '{1'b1, 1'b0, 1'b0};
    watch(8);
    watch(96);
    chk({ra[7:0], rb[7:0], pin_a_oe, pin_b_oe}, {8'hc, 8'h0, 2'b10}, "main out");
    clk_out_ctl = '{1'b0, 1'b1, 1'b1};
    watch(8);
    watch(200);
    chk({ra[7:0], rb[7:0], pin_a_oe, pin_b_oe}, {8'h0, 8'h4, 2'b01}, "sub out");
  endtask

  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    test_reset();
    test_ratios();
    test_low_speed();
    test_wait();
    test_stop();
    test_clk_out();
    test_reset();
    complete_run();
  end
endmodule
